// *** design/wdpc_top.sv ***
/*
  wdpc_top: watchdog configuration and HALT/STOP power-down control.
  Assumes the core reports each decoded opcode with a one-cycle strobe and
  an instruction-retire strobe, and honours cpu_clock_en_o and restart_o.
*/
// Local design decisions: the register addresses and the strobed register port.
// Function
// - upper five control-high bits writable only during first instruction after reset
// - three-bit period field selects watchdog time-out; 000 disables
// - period field resets to 001, shortest time-out
// - bit 7 lets watchdog reset the part during HALT
// - bit 3 resets set; set makes STOP a no-operation
// - HALT stops CPU clock, oscillator keeps timers and interrupts running
// - opcode 7F enters HALT, 6F enters STOP, no preceding nop needed
// - interrupt wakes HALT, service routine then resume after HALT
// - HALT ended by reset or watchdog restarts at 0020H
// - STOP shuts down oscillator and system clock
// - STOP left only by power-on reset or recovery; restart 0020H, flag set
// - reading STOP flag leaves it; software must clear it
// - low on recovery pin triggers recovery when configured as input and function
// - recovery waits power-on delay before executing at 20h
// - pin recovery keeps control registers at current values
`timescale 1ns/1ps
module wdpc_top (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [7:0] rdata_o,
  input wire logic opcode_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic instr_done_i,
  input wire logic irq_i,
  input wire logic recovery_input_pin_i,
  output logic cpu_clock_en_o,
  output logic osc_en_o,
  output logic sys_clock_en_o,
  output logic restart_o,
  output logic [15:0] restart_addr_o,
  output logic irq_wake_o,
  output logic wdt_reset_o,
  output logic halted_o,
  output logic stopped_o
);
  wdpc_pkg::wdpc_state_type state;
  wdpc_pkg::wdpc_state_type next_state;
  logic [7:0] ctl_high;
  logic [1:0] pin_cfg;
  logic stop_flag;
  logic first_instr;
  logic [7:0] rdata;
  logic restart;
  logic irq_wake;
  logic wdt_reset;
  logic [7:0] wait_cnt;

  // register port decode
  wire wr_ctl = write_i && (addr_i == wdpc_pkg::addr_ctl_high);
  wire wr_status = write_i && (addr_i == wdpc_pkg::addr_status);
  wire wr_pin = write_i && (addr_i == wdpc_pkg::addr_pin_cfg);
  wire [2:0] period = ctl_high[wdpc_pkg::period_msb:wdpc_pkg::period_lsb];
  wire halt_wdt_en = ctl_high[wdpc_pkg::halt_wdt_bit];
  wire stop_disabled = ctl_high[wdpc_pkg::stop_dis_bit];

  // opcode decode
  wire dec_halt = opcode_valid_i && (opcode_i == wdpc_pkg::op_halt) && (state == wdpc_pkg::st_run);
  wire dec_stop = opcode_valid_i && (opcode_i == wdpc_pkg::op_stop) && (state == wdpc_pkg::st_run)
    && !stop_disabled;

  // watchdog period select
  logic [23:0] wdt_terminal;
  always_comb begin
    case (period)
      3'h1: wdt_terminal = wdpc_pkg::wdt_p1;
      3'h2: wdt_terminal = wdpc_pkg::wdt_p2;
      3'h3: wdt_terminal = wdpc_pkg::wdt_p3;
      3'h4: wdt_terminal = wdpc_pkg::wdt_p4;
      3'h5: wdt_terminal = wdpc_pkg::wdt_p5;
      3'h6: wdt_terminal = wdpc_pkg::wdt_p6;
      3'h7: wdt_terminal = wdpc_pkg::wdt_p7;
      default: wdt_terminal = 24'h000000;
    endcase
  end

  // watchdog runs in RUN, and in HALT only when bit 7 is set
  wire wdt_active = (period != wdpc_pkg::period_off) && ((state == wdpc_pkg::st_run) ||
    ((state == wdpc_pkg::st_halt) && halt_wdt_en));
  wire wdt_hit;
  wdpc_counter #(
    .width(24)
  ) u_watchdog_timer (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .clear_i(!wdt_active || restart),
    .count_i(wdt_active),
    .terminal_i(wdt_terminal),
    .hit_o(wdt_hit)
  );

  // recovery pin qualifier, armed only in STOP when configured
  wire recov_armed = (state == wdpc_pkg::st_stop) && pin_cfg[wdpc_pkg::pin_input_bit]
    && pin_cfg[wdpc_pkg::pin_recov_bit];
  wire recov_seen;
  wdpc_sync_filter #(
    .cycles(wdpc_pkg::recovery_cycles)
  ) u_stop_recovery (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .enable_i(recov_armed),
    .level_n_i(recovery_input_pin_i),
    .seen_o(recov_seen)
  );

  wire wait_done = (wait_cnt == 8'(wdpc_pkg::power_on_cycles - 1));

  // power state sequencing
  always_comb begin
    next_state = state;
    case (state)
      wdpc_pkg::st_boot: next_state = wdpc_pkg::st_run;
      wdpc_pkg::st_run: begin
        if (wdt_hit) begin
          next_state = wdpc_pkg::st_run;
        end else if (dec_halt) begin
          next_state = wdpc_pkg::st_halt;
        end else if (dec_stop) begin
          next_state = wdpc_pkg::st_stop;
        end
      end
      wdpc_pkg::st_halt: begin
        if (wdt_hit || irq_i) begin
          next_state = wdpc_pkg::st_run;
        end
      end
      wdpc_pkg::st_stop: begin
        if (recov_seen) begin
          next_state = wdpc_pkg::st_wait;
        end
      end
      wdpc_pkg::st_wait: begin
        if (wait_done) begin
          next_state = wdpc_pkg::st_run;
        end
      end
      default: next_state = wdpc_pkg::st_boot;
    endcase
  end

  // state register and power-on delay counter
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= wdpc_pkg::st_boot;
      wait_cnt <= 8'h00;
    end else begin
      state <= next_state;
      wait_cnt <= (state == wdpc_pkg::st_wait) ? wait_cnt + 8'h01 : 8'h00;
    end
  end

  // first-instruction window after reset
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      first_instr <= 1'b1;
    end else if (instr_done_i && state != wdpc_pkg::st_boot) begin
      first_instr <= 1'b0;
    end
  end

  // control-high: upper five bits only in the window, reserved bits held zero
  wire upper_ok = first_instr && wr_ctl;
  wire [7:0] next_ctl_high = upper_ok ? (wdata_i & wdpc_pkg::ctl_high_upper_mask) : ctl_high;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_high <= wdpc_pkg::ctl_high_reset;
    end else begin
      ctl_high <= next_ctl_high;
    end
  end

  // pin configuration
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_cfg <= 2'h0;
    end else if (wr_pin) begin
      pin_cfg <= wdata_i[1:0];
    end
  end

  // stop flag: recovery sets and wins over a software clear; reads leave it
  wire set_flag = (state == wdpc_pkg::st_wait) && wait_done;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stop_flag <= 1'b0;
    end else if (set_flag) begin
      stop_flag <= 1'b1;
    end else if (wr_status && !wdata_i[wdpc_pkg::stop_flag_bit]) begin
      stop_flag <= 1'b0;
    end
  end

  // read mux
  wire [7:0] rd_mux = (addr_i == wdpc_pkg::addr_ctl_high) ? ctl_high :
    (addr_i == wdpc_pkg::addr_status) ? {7'h00, stop_flag} :
    (addr_i == wdpc_pkg::addr_pin_cfg) ? {6'h00, pin_cfg} : 8'h00;

  // read data, restart and wake pulses
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata <= 8'h00;
      restart <= 1'b0;
      irq_wake <= 1'b0;
      wdt_reset <= 1'b0;
    end else begin
      rdata <= read_i ? rd_mux : 8'h00;
      restart <= wdt_hit || set_flag || (state == wdpc_pkg::st_boot);
      irq_wake <= (state == wdpc_pkg::st_halt) && irq_i && !wdt_hit;
      wdt_reset <= wdt_hit;
    end
  end

  // clock gating outputs
  assign cpu_clock_en_o = (state == wdpc_pkg::st_run);
  assign osc_en_o = (state != wdpc_pkg::st_stop);
  assign sys_clock_en_o = (state != wdpc_pkg::st_stop) && (state != wdpc_pkg::st_wait);
  assign restart_o = restart;
  assign restart_addr_o = wdpc_pkg::restart_addr;
  assign irq_wake_o = irq_wake;
  assign wdt_reset_o = wdt_reset;
  assign halted_o = (state == wdpc_pkg::st_halt);
  assign stopped_o = (state == wdpc_pkg::st_stop);
  assign rdata_o = rdata;
endmodule : wdpc_top

// *** design/wdpc_pkg.sv ***
/*
  wdpc_pkg: constants shared by the watchdog and power-down control block.
  Assumes one 250 MHz clock; all counts are in cycles of that clock.
*/
package wdpc_pkg;
  // register map of the plain register port
  localparam logic [1:0] addr_ctl_high = 2'h0;
  localparam logic [1:0] addr_status = 2'h1;
  localparam logic [1:0] addr_pin_cfg = 2'h2;
  // timer control-high fields
  localparam int halt_wdt_bit = 7;
  localparam int period_msb = 6;
  localparam int period_lsb = 4;
  localparam int stop_dis_bit = 3;
  localparam logic [7:0] ctl_high_reset = 8'h98;
  localparam logic [7:0] ctl_high_upper_mask = 8'hF8;
  // status and pin configuration fields
  localparam int stop_flag_bit = 0;
  localparam int pin_input_bit = 0;
  localparam int pin_recov_bit = 1;
  // opcodes
  localparam logic [7:0] op_halt = 8'h7F;
  localparam logic [7:0] op_stop = 8'h6F;
  localparam logic [15:0] restart_addr = 16'h0020;
  // watchdog periods, crystal periods
  localparam logic [2:0] period_off = 3'h0;
  localparam logic [23:0] wdt_p1 = 24'h010000;
  localparam logic [23:0] wdt_p2 = 24'h020000;
  localparam logic [23:0] wdt_p3 = 24'h040000;
  localparam logic [23:0] wdt_p4 = 24'h080000;
  localparam logic [23:0] wdt_p5 = 24'h100000;
  localparam logic [23:0] wdt_p6 = 24'h200000;
  localparam logic [23:0] wdt_p7 = 24'h800000;
  // power-on delay: 128 crystal periods plus oscillator start of at most 5
  localparam int crystal_period_ns = 4;
  localparam int clk_period_ns = 4;
  localparam int por_periods = 128;
  localparam int ost_periods = 5;
  localparam int power_on_delay_ns = (por_periods + ost_periods) * crystal_period_ns;
  localparam int power_on_cycles = (power_on_delay_ns + clk_period_ns - 1) / clk_period_ns;
  // recovery pulse width, least 25 ns
  localparam int recovery_pulse_width_ns = 25;
  localparam int recovery_cycles = (recovery_pulse_width_ns + clk_period_ns - 1) / clk_period_ns;
  typedef enum logic [2:0] {
    st_boot = 3'b000,
    st_run = 3'b001,
    st_halt = 3'b010,
    st_stop = 3'b011,
    st_wait = 3'b100
  } wdpc_state_type;
endpackage : wdpc_pkg

// *** design/wdpc_counter.sv ***
/*
  wdpc_counter: up counter with clear and terminal compare.
  Assumes clear has priority and a terminal of zero never hits.
*/
`timescale 1ns/1ps
module wdpc_counter #(
  parameter int width = 24
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic clear_i,
  input wire logic count_i,
  input wire logic [width-1:0] terminal_i,
  output logic hit_o
);
  logic [width-1:0] count;
  logic [width-1:0] next_count;

  // next value and terminal compare
  assign next_count = clear_i ? '0 : (count_i ? count + 1'b1 : count);
  assign hit_o = count_i && !clear_i && (terminal_i != '0) && (count + 1'b1 == terminal_i);

  // count register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule : wdpc_counter

// *** design/wdpc_sync_filter.sv ***
/*
  wdpc_sync_filter: qualifies a low level on the recovery pin for a least width.
  Assumes the pin input is synchronous to the clock.
*/
`timescale 1ns/1ps
module wdpc_sync_filter #(
  parameter int cycles = 7
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  input wire logic level_n_i,
  output logic seen_o
);
  logic [7:0] width_cnt;

  // count consecutive low cycles while enabled
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      width_cnt <= 8'h00;
    end else if (!enable_i || level_n_i) begin
      width_cnt <= 8'h00;
    end else if (width_cnt != 8'(cycles)) begin
      width_cnt <= width_cnt + 8'h01;
    end
  end

  assign seen_o = (width_cnt == 8'(cycles));
endmodule : wdpc_sync_filter

// *** tb/wdpc_top_properties.sv ***
/*
  wdpc_checker: port-level timing checks of the power-down control.
  Assumes it is bound to wdpc_top; one clock, async active-low reset.
*/
`timescale 1ns/1ps
module wdpc_checker (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic opcode_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic irq_i,
  input wire logic recovery_input_pin_i,
  input wire logic cpu_clock_en_o,
  input wire logic osc_en_o,
  input wire logic sys_clock_en_o,
  input wire logic restart_o,
  input wire logic [15:0] restart_addr_o,
  input wire logic irq_wake_o,
  input wire logic wdt_reset_o,
  input wire logic halted_o,
  input wire logic stopped_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  logic [7:0] wait_cnt;
  wire logic in_wait;
  // post-recovery wait: oscillator up, system clock still held
  assign in_wait = !sys_clock_en_o && osc_en_o;
  // length of the current wait
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) wait_cnt <= 8'h00;
    else wait_cnt <= in_wait ? wait_cnt + 8'h01 : 8'h00;
  end
  property p_halt_entry; opcode_valid_i && cpu_clock_en_o && opcode_i == 8'h7F
    |=> halted_o && !cpu_clock_en_o; endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("halt entry");
  property p_halt_clk; halted_o |-> osc_en_o && sys_clock_en_o && !cpu_clock_en_o; endproperty
  a_halt_clk: assert property (p_halt_clk) else $error("halt clocks");
  property p_stop_clk; stopped_o |-> !osc_en_o && !sys_clock_en_o && !cpu_clock_en_o; endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("stop clocks");
  property p_stop_hold; stopped_o && recovery_input_pin_i |=> stopped_o; endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left early");
  // wake pulse is registered on the same edge that leaves HALT
  property p_irq_wake; halted_o && irq_i && !wdt_reset_o |=> cpu_clock_en_o && irq_wake_o;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq wake");
  property p_wdt_rst; wdt_reset_o |-> ##[0:1] restart_o && restart_addr_o == 16'h0020;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("wdt restart");
  property p_wait_len; $fell(in_wait) |-> wait_cnt == 8'(wdpc_pkg::power_on_cycles); endproperty
  a_wait_len: assert property (p_wait_len) else $error("wait length");
  property p_wait_rst; $fell(in_wait) |-> ##[0:1] restart_o && restart_addr_o == 16'h0020;
  endproperty
  a_wait_rst: assert property (p_wait_rst) else $error("recovery restart");
endmodule : wdpc_checker

// *** tb/wdpc_core_model.sv ***
/*
  wdpc_core_model: stand-in core issuing one instruction per request.
  Assumes the bench pulses go_i for one cycle while the core clock runs.
*/
`timescale 1ns/1ps
module wdpc_core_model (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic cpu_clock_en_i,
  input wire logic go_i,
  input wire logic [7:0] op_i,
  output logic opcode_valid_o,
  output logic [7:0] opcode_o,
  output logic instr_done_o
);
  // decode and retire only while clocked; idle opcode bus toggles
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      opcode_valid_o <= 1'b0;
      opcode_o <= 8'h00;
      instr_done_o <= 1'b0;
    end else begin
      opcode_valid_o <= go_i && cpu_clock_en_i;
      opcode_o <= (go_i && cpu_clock_en_i) ? op_i : ~opcode_o;
      instr_done_o <= go_i && cpu_clock_en_i;
    end
  end
endmodule : wdpc_core_model

// *** tb/tb_top.sv ***
/*
  tb_top: self-checking bench for the watchdog and power-down control.
  Assumes the design package, design files and checker are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  logic clock_i = 1'b0, resetn_i = 1'b0, write_i = 1'b0, read_i = 1'b0, irq_i = 1'b0;
  logic pin = 1'b1, go = 1'b0, ovalid, idone, cen, oen, sen, rst_p, wake, wdr, hlt, stp;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, op = 8'h00, opc, rdata;
  logic [15:0] raddr;
  int error_cnt = 0, n_compared = 0, cyc = 0, t0 = 0, n = 0;
  logic [9:0] rows [4] = '{10'h098, 10'h100, 10'h200, 10'h300};
  // clock and cycle count
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) cyc <= cyc + 1;
  wdpc_top dut (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata), .opcode_valid_i(ovalid),
    .opcode_i(opc), .instr_done_i(idone), .irq_i(irq_i), .recovery_input_pin_i(pin),
    .cpu_clock_en_o(cen), .osc_en_o(oen), .sys_clock_en_o(sen), .restart_o(rst_p),
    .restart_addr_o(raddr), .irq_wake_o(wake), .wdt_reset_o(wdr), .halted_o(hlt),
    .stopped_o(stp));
  wdpc_core_model core (.clock_i(clock_i), .resetn_i(resetn_i), .cpu_clock_en_i(cen),
    .go_i(go), .op_i(op), .opcode_valid_o(ovalid), .opcode_o(opc), .instr_done_o(idone));
  // bench tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock_i);
    addr <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1 chk("rdata", {24'h0, e}, {24'h0, rdata});
  endtask : rd
  task automatic exec(input logic [7:0] c);
    @(posedge clock_i);
    op <= c;
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask : exec
  // bounded wait: 0 wake pulse, 1 watchdog pulse, 2 restart pulse
  task automatic wait_on(input int sel, input int lim);
    n = 0;
    while ((sel == 0 ? wake : sel == 1 ? wdr : rst_p) !== 1'b1) begin
      @(posedge clock_i);
      #1 n++;
      if (n > lim) begin
        chk("wait bound", 1, 0);
        conclude();
      end
    end
  endtask : wait_on
  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    t0 = cyc;
    repeat (2) @(posedge clock_i);
  endtask : do_reset
  // main sequence
  initial begin
    do_reset();
    foreach (rows[i]) rd(rows[i][9:8], rows[i][7:0]);
    exec(8'h6F);
    chk("stop as nop", 0, stp);
    exec(8'h7F);
    chk("halt state", 2, {hlt, cen});
    irq_i <= 1'b1;
    wait_on(0, 20);
    irq_i <= 1'b0;
    chk("resumed", 1, {hlt, cen});
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h98);
    wait_on(1, 70000);
    chk("timeout", 1, (cyc - t0 >= 65536) && (cyc - t0 <= 65548));
    do_reset();
    wr(2'h0, 8'h00);
    exec(8'h00);
    wr(2'h0, 8'hF8);
    rd(2'h0, 8'h00);
    wr(2'h2, 8'h03);
    exec(8'h6F);
    chk("stop clocks", 4, {stp, oen, sen});
    repeat (20) @(posedge clock_i);
    #1 chk("still stopped", 1, stp);
    pin <= 1'b0;
    wait_on(2, 400);
    chk("recovery wait", 1, n >= 141);
    pin <= 1'b1;
    rd(2'h1, 8'h01);
    rd(2'h1, 8'h01);
    rd(2'h0, 8'h00);
    rd(2'h2, 8'h03);
    wr(2'h1, 8'h00);
    rd(2'h1, 8'h00);
    conclude();
  end
endmodule : tb_top

bind wdpc_top wdpc_checker chk (.clock_i(clock_i), .resetn_i(resetn_i),
  .opcode_valid_i(opcode_valid_i), .opcode_i(opcode_i), .irq_i(irq_i),
  .recovery_input_pin_i(recovery_input_pin_i), .cpu_clock_en_o(cpu_clock_en_o),
  .osc_en_o(osc_en_o), .sys_clock_en_o(sys_clock_en_o), .restart_o(restart_o),
  .restart_addr_o(restart_addr_o), .irq_wake_o(irq_wake_o), .wdt_reset_o(wdt_reset_o),
  .halted_o(halted_o), .stopped_o(stopped_o));
